// >>> include/padc_cfg.svh
// Purpose: Constants for the pipelined converter digital output port.
// Assumes: One clock, sys_clk_in, at 20 MHz.
// Notes: Included by the package and the port module.
// Overview of operation
// - Output enable low drives pins, high releases.
// - Conversion continues whatever the enable level.
// - Sleep request holds low power, outputs undefined.
// - Twelve-bit offset binary word, valid when enabled.
// - Sample each rising edge, seven-cycle delay while the skid buffer holds a word.
// - Exactly one output word per clock.
`ifndef PADC_CFG_SVH
`define PADC_CFG_SVH
`define PADC_DATA_W 12
`define PADC_PIPE_DEPTH 6
`define PADC_UNDEF_WORD 12'hA5A
`define PADC_RST_WORD 12'h000
`endif

// >>> include/padc_pkg.sv
// Purpose: Types shared by the converter port.
// Assumes: Constants come from padc_cfg.svh.
// Notes: Holds types only.
`include "padc_cfg.svh"
package padc_pkg;
  typedef logic [`PADC_DATA_W-1:0] padc_word_t;
endpackage

// >>> rtl/padc_port.sv
// Purpose: Digital output port of a pipelined converter: delay line, skid buffer, output drivers.
// Assumes: Samples arrive as words on sys_clk_in; enable and sleep are pins and are synchronised.
// Notes: Pin data is two signals; the bench resolves the wire level from the enable.
`timescale 1ns/1ps
`include "padc_cfg.svh"
module padc_port
  import padc_pkg::*;
#(
  parameter int DATA_W = `PADC_DATA_W,
  parameter int PIPE_DEPTH = `PADC_PIPE_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Sampled analog value as a digital word.
  input wire logic [DATA_W-1:0] sample_in,
  // Control pins.
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  // Receiver stall; a word is lost only if the buffer overflows.
  input wire logic rx_ready_in,
  // Data pins.
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe_out,
  output logic data_valid_out,
  output logic low_power_out
);

  // =====================================================
  // Elaboration checks
  // The pins are fixed at the word width, and the delay line needs at least two
  // stages so that the output register can supply the last cycle of delay.
  if (DATA_W != `PADC_DATA_W || PIPE_DEPTH < 2) begin : g_bad_params
    $error("padc_port: unsupported parameters.");
  end

  // =====================================================
  // Pin synchronisers
  logic [1:0] oe_n_sync;
  logic [1:0] sleep_sync;
  // Two stages guard against metastability; only stage 1 is read.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_n_sync <= 2'h3;
      sleep_sync <= 2'h0;
    end else begin
      oe_n_sync <= {oe_n_sync[0], output_enable_n_in};
      sleep_sync <= {sleep_sync[0], sleep_request_in};
    end
  end
  wire oe_n = oe_n_sync[1];
  wire sleeping = sleep_sync[1];

  // =====================================================
  // Conversion pipeline
  logic [DATA_W-1:0] pipe [PIPE_DEPTH];
  // A word is taken each rising edge, even while disabled.
  // Sleep corrupts the pipeline contents, so a fixed junk word is loaded.
  wire [DATA_W-1:0] stage_in = sleeping ? DATA_W'(`PADC_UNDEF_WORD) : sample_in;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < PIPE_DEPTH; i++) pipe[i] <= DATA_W'(`PADC_RST_WORD);
    end else begin
      pipe[0] <= stage_in;
      for (int i = 1; i < PIPE_DEPTH; i++) pipe[i] <= pipe[i-1];
    end
  end
  // Pipe output is one stage short; the output register adds the sixth cycle.
  wire [DATA_W-1:0] pipe_word = pipe[PIPE_DEPTH-2];

  // =====================================================
  // Two-entry skid buffer
  logic [DATA_W-1:0] buf_word [2];
  logic [1:0] buf_cnt;
  wire buf_in_ready = (buf_cnt != 2'h2);
  wire buf_out_valid = (buf_cnt != 2'h0);
  wire push = buf_in_ready;
  wire pop = buf_out_valid && rx_ready_in;
  wire [1:0] next_buf_cnt = buf_cnt + 2'(push) - 2'(pop);
  // Full buffer drops the newest word; the converter cannot stall.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_cnt <= 2'h0;
      buf_word[0] <= DATA_W'(`PADC_RST_WORD);
      buf_word[1] <= DATA_W'(`PADC_RST_WORD);
    end else begin
      buf_cnt <= next_buf_cnt;
      if (pop) buf_word[0] <= buf_word[1];
      if (push) buf_word[(pop ? buf_cnt - 2'h1 : buf_cnt) == 2'h0 ? 0 : 1] <= pipe_word;
    end
  end

  // =====================================================
  // Output drivers
  // Enable releases all pins; buffer feeds pins as offset binary.
  wire [DATA_W-1:0] next_data = buf_out_valid ? buf_word[0] : pipe_word;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out <= DATA_W'(`PADC_RST_WORD);
      data_oe_out <= '0;
      data_valid_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      data_out <= next_data;
      data_oe_out <= {DATA_W{~oe_n}};
      data_valid_out <= ~oe_n & ~sleeping;
      low_power_out <= sleeping;
    end
  end

  // =====================================================
  // Assertions
  // All properties share the conversion clock and are held off during reset.

  // =====================================================
  // Output driver checks

  // The driver enable follows the synchronised pin one edge later.
  a_oe_drives: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 data_oe_out == {DATA_W{~$past(oe_n)}})
    else $error("Enable mismatch.");

  // A split enable would leave some pins floating and others fighting the bus.
  a_oe_uniform: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    data_oe_out == '0 || data_oe_out == '1)
    else $error("Enable not uniform.");

  // A high enable pin releases every data pin.
  a_oe_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    oe_n |=> data_oe_out == '0)
    else $error("Pins not released.");

  // A low enable pin drives every data pin.
  a_oe_engage: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !oe_n |=> data_oe_out == '1)
    else $error("Pins not driven.");

  // =====================================================
  // Valid and low-power flag checks

  // Words are never marked valid while the converter sleeps.
  a_valid_gated: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sleeping |=> !data_valid_out)
    else $error("Valid during sleep.");

  // Valid needs both pins quiet, one edge after they are synchronised.
  a_valid_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 data_valid_out == $past(~oe_n & ~sleeping))
    else $error("Valid flag mismatch.");

  // Released pins can never carry a valid word.
  a_valid_needs_oe: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    oe_n |=> !data_valid_out)
    else $error("Valid while released.");

  // The low-power flag rises one edge after the synchronised request.
  a_low_power: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sleeping |=> low_power_out)
    else $error("Low power flag missing.");

  // The flag clears one edge after the synchronised request is withdrawn.
  a_power_resume: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !sleeping |=> !low_power_out)
    else $error("Low power flag stuck.");

  // =====================================================
  // Conversion pipeline checks

  // The delay line hands on each taken word one edge short of its stage count.
  // The skid stage and the output register then complete the full latency.
  a_pipe_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in, PIPE_DEPTH - 1) |-> pipe_word == $past(stage_in, PIPE_DEPTH - 1))
    else $error("Pipeline delay wrong.");

  // Disabled pins do not stall conversion.
  a_keep_conv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    oe_n |=> pipe[0] == $past(stage_in))
    else $error("Pipeline stalled.");

  // Every edge moves the line by exactly one word.
  a_one_word: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    1 |=> pipe[1] == $past(pipe[0]))
    else $error("Word rate broken.");

  // The last stage also moves once per edge.
  a_stage_shift: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    1 |=> pipe[PIPE_DEPTH-1] == $past(pipe[PIPE_DEPTH-2]))
    else $error("Last stage stalled.");

  // Sleep loads the fixed junk word, so corrupt samples are recognisable.
  a_sleep_junk: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sleeping |=> pipe[0] == DATA_W'(`PADC_UNDEF_WORD))
    else $error("Sleep word wrong.");

  // Awake, the first stage takes the live sample.
  a_wake_sample: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !sleeping |=> pipe[0] == $past(sample_in))
    else $error("Live sample lost.");

  // =====================================================
  // Skid buffer checks

  // The count never passes the two entries that exist.
  a_buf_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    buf_cnt <= 2'h2)
    else $error("Buffer overflow.");

  // A push and a pop in one cycle leave the count alone.
  a_buf_steady: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (push && pop) |=> buf_cnt == $past(buf_cnt))
    else $error("Buffer count drift.");

  // A full buffer with a stalled receiver stays full and drops new words.
  a_buf_drop: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (buf_cnt == 2'h2 && !rx_ready_in) |=> buf_cnt == 2'h2)
    else $error("Full buffer changed.");

  // =====================================================
  // Data path checks

  // An empty buffer passes the delay line straight to the pins.
  a_bypass_word: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    buf_cnt == 2'h0 |=> data_out == $past(pipe_word))
    else $error("Bypass word wrong.");

  // A holding buffer shows its oldest word first.
  a_head_word: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    buf_cnt != 2'h0 |=> data_out == $past(buf_word[0]))
    else $error("Head word wrong.");

  // A popped head is replaced by the second entry when no push lands there.
  a_head_advance: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pop && !push && buf_cnt == 2'h2) |=> buf_word[0] == $past(buf_word[1]))
    else $error("Head not advanced.");

endmodule // padc_port

// >>> sim/padc_capture.sv
// Purpose: Capture-side model of the word latch.
// Assumes: Pin level is resolved by the bench.
// Notes: Never stalls, so the port buffer never holds more than one word.
`timescale 1ns/1ps
// ====
// Capture model
module padc_capture
  import padc_pkg::*;
(
  // Clock and pins.
  input wire logic clk_in,
  input wire padc_word_t pin_in,
  input wire logic valid_in,
  // Ready and latched word.
  output logic ready_out,
  output padc_word_t word_out
);
  // One load per pin: bus sharing via enable would add capacitance.
  assign ready_out = 1'b1;
  // The falling edge sits mid-cycle, clear of output changes.
  always @(negedge clk_in) begin
    if (valid_in) word_out <= pin_in;
  end
endmodule // padc_capture

// >>> sim/pipelined_adc_digital_port_bench.sv
// Purpose: Self-checking bench of the converter port.
// Assumes: 20 MHz clock; receiver always ready.
// Notes: Words in flight across sleep are skipped.
`timescale 1ns/1ps
// ====
// Bench
module pipelined_adc_digital_port_bench;
  import padc_pkg::*;
  logic clk = 0, rst = 1, en_n = 1, slp = 0, rdy, vld, lp;
  padc_word_t smp = '0, dat, oe, pin, cap;
  padc_word_t sh[1024];
  logic eh[1024], ph[1024];
  int n = 0, cyc = 0, quiet = 0, miscompares = 0, compares = 0;
  bit cap_ok = 0;
  // Clock, 50 ns period, free running at even duty.
  always #25 clk = ~clk;
  // Pins float unless all drivers are on.
  assign pin = (oe === 12'hFFF) ? dat : 'z;
  padc_port i_padc_port (.sys_clk_in(clk), .rst_in(rst), .sample_in(smp), .output_enable_n_in(en_n),
    .sleep_request_in(slp), .rx_ready_in(rdy), .data_out(dat), .data_oe_out(oe), .data_valid_out(vld),
    .low_power_out(lp));
  padc_capture i_padc_capture (.clk_in(clk), .pin_in(pin), .valid_in(vld), .ready_out(rdy), .word_out(cap));
  // Comparisons.
  task automatic check_word(input padc_word_t got, input padc_word_t exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({11'h000, got}, {11'h000, exp});
  endtask
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the 610 cycles of the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      conclude;
    end
  end
  // Check settled outputs, then drive at the falling edge.
  initial begin
    void'($urandom(55));
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (600) begin
      @(negedge clk);
      if (n >= 12) begin
        check_word(oe, eh[n-3] ? 12'h000 : 12'hFFF);
        check_bit(lp, ph[n-3]);
        check_bit(vld, !eh[n-3] && !ph[n-3]);
        if (!eh[n-3] && quiet == 0) check_word(pin, sh[n-7]);
      end
      if (cap_ok) check_word(cap, sh[n-8]);
      cap_ok = (n >= 12) && !eh[n-3] && !ph[n-3] && quiet == 0;
      en_n = (n % 64) inside {[20:29]};
      slp = (n % 150) inside {[90:99]};
      smp = (n % 16 == 0) ? 12'hFFF : (n % 16 == 1) ? 12'h000 : 12'($urandom);
      quiet = slp ? 12 : (quiet > 0 ? quiet - 1 : 0);
      sh[n] = smp;
      eh[n] = en_n;
      ph[n] = slp;
      n++;
    end
    conclude;
  end
endmodule // pipelined_adc_digital_port_bench
